// *** logic/rsr_pkg.sv ***
package rsr_pkg;

    // Register addresses on the eight-bit host bus
    localparam logic [2:0] ADDR_RANDOM   = 3'h0;
    localparam logic [2:0] ADDR_STATUS   = 3'h1;
    localparam logic [2:0] ADDR_EVENT    = 3'h2;
    localparam logic [2:0] ADDR_PATTERN  = 3'h3;
    localparam logic [2:0] ADDR_FLOOR    = 3'h4;
    localparam logic [2:0] ADDR_CEILING  = 3'h5;
    localparam logic [2:0] ADDR_REMAIN   = 3'h6;
    localparam logic [2:0] ADDR_MONITOR  = 3'h7;

    // Status/command layout: low six bits live, top two read zero
    localparam int         STATUS_LIVE_BITS = 6;
    localparam logic [1:0] STATUS_TOP_VALUE = 2'h0;

    // Reset values
    localparam logic [7:0] EVENT_RESET   = 8'h00;
    localparam logic [3:0] PATTERN_RESET = 4'h0;
    localparam logic [7:0] FLOOR_RESET   = 8'h00;
    localparam logic [7:0] CEILING_RESET = 8'h00;
    localparam logic [7:0] REMAIN_RESET  = 8'h00;
    localparam logic [7:0] MONITOR_RESET = 8'h00;
    localparam logic [7:0] BUS_RESET     = 8'h00;

    // Run-up test figures
    localparam logic [9:0] TEST_SAMPLES  = 10'h3E8;
    localparam logic [7:0] EVENT_MAX     = 8'hFF;
    localparam logic [7:0] BYTE_PRESET   = 8'h43;
    localparam logic [6:0] BYTE_TOTAL    = 7'h43;

    // Fixed event counts in alarm-test mode, pattern p at bits [8p +: 8]
    localparam logic [127:0] ALARM_EVENTS = 128'h2A473F1D38425228_4E153B55254E21A0;

    // Fixed random register contents in alarm-test mode, first byte read first
    localparam logic [7:0] ALARM_BYTES [0:66] = '{
        8'h71, 8'hF0, 8'hEC, 8'hA1, 8'h58, 8'h73, 8'hF0, 8'hEC, 8'hA1, 8'h58, 8'h73, 8'hF0,
        8'hE8, 8'hA1, 8'h58, 8'h73, 8'hB0, 8'hE8, 8'hA1, 8'h58, 8'h73, 8'hB0, 8'hE8, 8'hA1,
        8'hC8, 8'h73, 8'hB0, 8'hE8, 8'hA1, 8'hC8, 8'h73, 8'hB0, 8'hE0, 8'hA1, 8'hC8, 8'h73,
        8'hB0, 8'hE0, 8'hA1, 8'hC8, 8'h61, 8'hB0, 8'hE0, 8'hA1, 8'hC9, 8'h61, 8'hB0, 8'hE0,
        8'hA1, 8'hC9, 8'h61, 8'hB0, 8'hA2, 8'hA1, 8'hC9, 8'h61, 8'hB0, 8'hA2, 8'hA1, 8'hC9,
        8'h41, 8'hB0, 8'hA2, 8'hA9, 8'hC9, 8'h41, 8'hB0
    };

    // Run-up test sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_DONE = 3'b100
    } rsr_state_t;

endpackage

// *** logic/rsr_alarm_rom.sv ***
module rsr_alarm_rom (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       ce_in,
    // Read port
    input  wire logic [6:0] index_in,
    output logic      [7:0] data_out
);

    // Registered read; past the last byte the port shows zero
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_out <= rsr_pkg::BUS_RESET;
        end else if (ce_in) begin
            if (index_in < rsr_pkg::BYTE_TOTAL) begin
                data_out <= rsr_pkg::ALARM_BYTES[index_in];
            end else begin
                data_out <= rsr_pkg::BUS_RESET;
            end
        end
    end

endmodule // rsr_alarm_rom

// *** logic/rsr_status_regs.sv ***
//Contract
// - Status bits seven and six read zero
// - Event count read-only, last completed test
// - Event count saturates at FF
// - Master reset clears event count
// - Pattern register shows last test pattern
// - Pattern counter advances on passing test
// - Failed test keeps pattern for retry
// - Master reset leaves pattern state alone
// - Pattern counter counts on from any state
// - Lower limit readable and writable
// - Upper limit readable and writable
// - Ready rising presets byte counter 43
// - Byte counter counts down, holds zero
// - Monitor captures shift-register input byte
// - Monitor loads on sample clock rise
// - Alarm mode gives fixed event counts
// - Alarm mode gives fixed random bytes
// - Thousand nibble compares, count matches
// - Count outside limits fails test
// - Alarm command loads known sequence
module rsr_status_regs (
    // Clock, reset, enable
    input  wire logic       CLK_IN,
    input  wire logic       RST_N_IN,
    input  wire logic       CE_IN,
    // Host bus
    input  wire logic       CS_N_IN,
    input  wire logic       RD_N_IN,
    input  wire logic       WR_N_IN,
    input  wire logic [2:0] ADDR_IN,
    input  wire logic [7:0] DATA_IN,
    output logic      [7:0] DATA_OUT,
    output logic            DATA_OE_OUT,
    // Device state from the rest of the chip
    input  wire logic       MASTER_RESET_PIN_IN,
    input  wire logic       ALARM_SELFTEST_COMMAND_IN,
    input  wire logic       RANDOM_READY_FLAG_IN,
    input  wire logic [5:0] STATUS_BITS_IN,
    input  wire logic [7:0] RANDOM_BYTE_IN,
    // Run-up datapath
    input  wire logic       TEST_START_IN,
    input  wire logic       SAMPLE_VALID_IN,
    input  wire logic [3:0] SAMPLE_NIBBLE_IN,
    output logic            TEST_BUSY_OUT,
    output logic            TEST_PASS_OUT,
    output logic            TEST_FAIL_OUT,
    output logic      [3:0] PATTERN_COUNT_OUT,
    // Monitor tap
    input  wire logic       MONITOR_SAMPLE_CLOCK_IN,
    input  wire logic [7:0] MONITOR_BYTE_IN
);

    rsr_pkg::rsr_state_t state;
    logic [7:0] match_event_count;
    logic [3:0] test_pattern_value;
    logic [3:0] pattern_count;
    logic [7:0] runup_floor;
    logic [7:0] runup_ceiling;
    logic [7:0] bytes_remaining;
    logic [7:0] raw_input_monitor;
    logic [7:0] match_acc;
    logic [9:0] sample_count;
    logic [7:0] test_result;
    logic       test_pass;
    logic       rd_prev;
    logic       wr_prev;
    logic [2:0] rd_addr;
    logic [2:0] wr_addr;
    logic [7:0] wr_data;
    logic       ready_prev;
    logic       monitor_sample_clock_prev;
    logic [7:0] rom_data;
    logic [7:0] next_data;
    logic       rd_active;
    logic       wr_active;
    logic       rd_done;
    logic       wr_done;
    logic       ready_rise;

    // Bus strobes are synchronous; an access ends when its strobe releases
    assign rd_active  = !CS_N_IN && !RD_N_IN;
    assign wr_active  = !CS_N_IN && !WR_N_IN;
    assign rd_done    = rd_prev && !rd_active;
    assign wr_done    = wr_prev && !wr_active;
    assign ready_rise = RANDOM_READY_FLAG_IN && !ready_prev;

    // Strobe history and captured address/data
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rd_prev    <= 1'b0;
            wr_prev    <= 1'b0;
            rd_addr    <= rsr_pkg::ADDR_RANDOM;
            wr_addr    <= rsr_pkg::ADDR_RANDOM;
            wr_data    <= rsr_pkg::BUS_RESET;
            ready_prev <= 1'b0;
            monitor_sample_clock_prev  <= 1'b0;
        end else if (CE_IN) begin
            rd_prev    <= rd_active;
            wr_prev    <= wr_active;
            ready_prev <= RANDOM_READY_FLAG_IN;
            monitor_sample_clock_prev  <= MONITOR_SAMPLE_CLOCK_IN;
            if (rd_active) begin
                rd_addr <= ADDR_IN;
            end
            // Data is taken while the strobe is low, so the last value before release wins
            if (wr_active) begin
                wr_addr <= ADDR_IN;
                wr_data <= DATA_IN;
            end
        end
    end

    // Limit registers, the only host-writable state here
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            runup_floor   <= rsr_pkg::FLOOR_RESET;
            runup_ceiling <= rsr_pkg::CEILING_RESET;
        end else if (CE_IN && wr_done) begin
            if (wr_addr == rsr_pkg::ADDR_FLOOR) begin
                runup_floor <= wr_data;
            end else if (wr_addr == rsr_pkg::ADDR_CEILING) begin
                runup_ceiling <= wr_data;
            end
            // Other addresses: read-only here, write dropped
        end
    end

    // Alarm-test contents stand in for the random bytes; index follows the down counter
    rsr_alarm_rom u_rom (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .ce_in    (CE_IN),
        .index_in (7'(rsr_pkg::BYTE_PRESET - bytes_remaining)),
        .data_out (rom_data)
    );

    // Read data mux
    always_comb begin
        next_data = rsr_pkg::BUS_RESET;
        if (ADDR_IN == rsr_pkg::ADDR_RANDOM) begin
            next_data = ALARM_SELFTEST_COMMAND_IN ? rom_data : RANDOM_BYTE_IN;
        end else if (ADDR_IN == rsr_pkg::ADDR_STATUS) begin
            next_data = {rsr_pkg::STATUS_TOP_VALUE, STATUS_BITS_IN};
        end else if (ADDR_IN == rsr_pkg::ADDR_EVENT) begin
            next_data = match_event_count;
        end else if (ADDR_IN == rsr_pkg::ADDR_PATTERN) begin
            next_data = {4'h0, test_pattern_value};
        end else if (ADDR_IN == rsr_pkg::ADDR_FLOOR) begin
            next_data = runup_floor;
        end else if (ADDR_IN == rsr_pkg::ADDR_CEILING) begin
            next_data = runup_ceiling;
        end else if (ADDR_IN == rsr_pkg::ADDR_REMAIN) begin
            next_data = bytes_remaining;
        end else begin
            next_data = raw_input_monitor;
        end
    end

    // Registered read data; the pins drive only during a selected read
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            DATA_OUT <= rsr_pkg::BUS_RESET;
        end else if (CE_IN) begin
            DATA_OUT <= next_data;
        end
    end
    assign DATA_OE_OUT = rd_active;

    // Remaining-byte down counter; a preset wins over a read in the same cycle
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            bytes_remaining <= rsr_pkg::REMAIN_RESET;
        end else if (CE_IN) begin
            if (ready_rise) begin
                bytes_remaining <= rsr_pkg::BYTE_PRESET;
            end else if (rd_done && rd_addr == rsr_pkg::ADDR_RANDOM && bytes_remaining != 8'h00) begin
                bytes_remaining <= bytes_remaining - 8'h01;
            end
        end
    end

    // Monitor tap: the sample clock is an ordinary synchronous input, edge found by compare
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            raw_input_monitor <= rsr_pkg::MONITOR_RESET;
        end else if (CE_IN && MONITOR_SAMPLE_CLOCK_IN && !monitor_sample_clock_prev) begin
            raw_input_monitor <= MONITOR_BYTE_IN;
        end
    end

    // End-of-test result; alarm mode substitutes the pattern's fixed count for the match count
    always_comb begin
        test_result = ALARM_SELFTEST_COMMAND_IN ? rsr_pkg::ALARM_EVENTS[{pattern_count, 3'h0} +: 8]
                                                : match_acc;
        test_pass   = (test_result >= runup_floor) && (test_result <= runup_ceiling);
    end

    // Run-up sequencer; master reset aborts the test but spares the pattern
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state        <= rsr_pkg::ST_IDLE;
            match_acc    <= rsr_pkg::EVENT_RESET;
            sample_count <= 10'h000;
        end else if (CE_IN) begin
            if (MASTER_RESET_PIN_IN) begin
                state        <= rsr_pkg::ST_IDLE;
                match_acc    <= rsr_pkg::EVENT_RESET;
                sample_count <= 10'h000;
            end else begin
                case (state)
                    rsr_pkg::ST_IDLE: begin
                        if (TEST_START_IN) begin
                            state        <= rsr_pkg::ST_RUN;
                            match_acc    <= rsr_pkg::EVENT_RESET;
                            sample_count <= 10'h000;
                        end
                    end
                    rsr_pkg::ST_RUN: begin
                        if (SAMPLE_VALID_IN) begin
                            // Saturate instead of wrapping so a stuck source still fails high
                            if (SAMPLE_NIBBLE_IN == pattern_count && match_acc != rsr_pkg::EVENT_MAX) begin
                                match_acc <= match_acc + 8'h01;
                            end
                            sample_count <= sample_count + 10'h001;
                            if (sample_count == rsr_pkg::TEST_SAMPLES - 10'h001) begin
                                state <= rsr_pkg::ST_DONE;
                            end
                        end
                    end
                    rsr_pkg::ST_DONE: begin
                        state <= rsr_pkg::ST_IDLE;
                    end
                    default: begin
                        state <= rsr_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Event count: loaded at completion, cleared by master reset
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            match_event_count <= rsr_pkg::EVENT_RESET;
        end else if (CE_IN) begin
            if (MASTER_RESET_PIN_IN) begin
                match_event_count <= rsr_pkg::EVENT_RESET;
            end else if (state == rsr_pkg::ST_DONE) begin
                match_event_count <= test_result;
            end
        end
    end

    // Pattern state; reset only by power-on, any start value is legal
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pattern_count      <= rsr_pkg::PATTERN_RESET;
            test_pattern_value <= rsr_pkg::PATTERN_RESET;
        end else if (CE_IN && !MASTER_RESET_PIN_IN && state == rsr_pkg::ST_DONE) begin
            test_pattern_value <= pattern_count;
            if (test_pass) begin
                pattern_count <= pattern_count + 4'h1;
            end
            // A failing test keeps the pattern for the retry
        end
    end

    // Result pulses
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            TEST_PASS_OUT <= 1'b0;
            TEST_FAIL_OUT <= 1'b0;
        end else if (CE_IN) begin
            TEST_PASS_OUT <= state == rsr_pkg::ST_DONE && !MASTER_RESET_PIN_IN && test_pass;
            TEST_FAIL_OUT <= state == rsr_pkg::ST_DONE && !MASTER_RESET_PIN_IN && !test_pass;
        end
    end

    assign TEST_BUSY_OUT     = state != rsr_pkg::ST_IDLE;
    assign PATTERN_COUNT_OUT = pattern_count;

    // Checks
    property p_status_top;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        CE_IN && ADDR_IN == rsr_pkg::ADDR_STATUS |=> DATA_OUT[7:6] == 2'h0 && DATA_OUT[5:0] == $past(STATUS_BITS_IN);
    endproperty
    a_status_top: assert property (p_status_top) else $error("status top bits not zero");

    property p_event_ro;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        CE_IN && state != rsr_pkg::ST_DONE && !MASTER_RESET_PIN_IN |=> $stable(match_event_count);
    endproperty
    a_event_ro: assert property (p_event_ro) else $error("event count changed outside completion");

    property p_mr_clear;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        CE_IN && MASTER_RESET_PIN_IN |=> match_event_count == 8'h00 && state == rsr_pkg::ST_IDLE;
    endproperty
    a_mr_clear: assert property (p_mr_clear) else $error("master reset did not clear event count");

    property p_pattern_hold;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        MASTER_RESET_PIN_IN |=> $stable(pattern_count) && $stable(test_pattern_value);
    endproperty
    a_pattern_hold: assert property (p_pattern_hold) else $error("master reset moved pattern");

    property p_pat_adv;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        TEST_PASS_OUT |-> pattern_count == $past(pattern_count) + 4'h1
                          && test_pattern_value == $past(pattern_count);
    endproperty
    a_pat_adv: assert property (p_pat_adv) else $error("pattern did not advance on pass");

    property p_pat_fail;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        TEST_FAIL_OUT |-> $stable(pattern_count)
                          && (match_event_count < runup_floor || match_event_count > runup_ceiling);
    endproperty
    a_pat_fail: assert property (p_pat_fail) else $error("fail moved pattern or count in range");

    property p_preset;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        CE_IN && RANDOM_READY_FLAG_IN && !ready_prev |=> bytes_remaining == 8'h43;
    endproperty
    a_preset: assert property (p_preset) else $error("byte counter not preset to 43");

    property p_count_down;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        CE_IN && !ready_rise && rd_done && rd_addr == rsr_pkg::ADDR_RANDOM
        |=> bytes_remaining == ($past(bytes_remaining) == 8'h00 ? 8'h00 : $past(bytes_remaining) - 8'h01);
    endproperty
    a_count_down: assert property (p_count_down) else $error("byte counter step wrong");

    property p_monitor;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        CE_IN && MONITOR_SAMPLE_CLOCK_IN && !monitor_sample_clock_prev |=> raw_input_monitor == $past(MONITOR_BYTE_IN);
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor missed sample edge");

    property p_alarm_count;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        TEST_PASS_OUT && $past(ALARM_SELFTEST_COMMAND_IN)
        |-> match_event_count == rsr_pkg::ALARM_EVENTS[{test_pattern_value, 3'h0} +: 8];
    endproperty
    a_alarm_count: assert property (p_alarm_count) else $error("alarm event count wrong");

    property p_saturate;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        match_acc == 8'hFF && !MASTER_RESET_PIN_IN && state == rsr_pkg::ST_RUN |=> match_acc == 8'hFF;
    endproperty
    a_saturate: assert property (p_saturate) else $error("event count wrapped");

    c_pass: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN) TEST_PASS_OUT);
    c_fail: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN) TEST_FAIL_OUT);
    c_drain: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        bytes_remaining == 8'h01 ##[1:50] bytes_remaining == 8'h00);
    c_limit_write: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        wr_done && wr_addr == rsr_pkg::ADDR_CEILING);

endmodule // rsr_status_regs

// *** dv/rsr_host_model.sv ***
module rsr_host_model (
    // Bus clock
    input  wire logic       clk_in,
    // Bus drive
    output logic            cs_n_out,
    output logic            rd_n_out,
    output logic            wr_n_out,
    output logic      [2:0] addr_out,
    output logic      [7:0] data_out,
    // Read return
    input  wire logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus, strobes high
    initial begin
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        addr_out = 3'h0;
        data_out = 8'h5A;
    end

    // Write cycle: strobe held two edges, device commits on release
    task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        data_out <= d;
        cs_n_out <= 1'b0;
        wr_n_out <= 1'b0;
        repeat (2) @(posedge clk_in);
        cs_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        data_out <= ~d; // Released bus must not keep the old value
        @(posedge clk_in);
    endtask

    // Read cycle: allows the slower alarm byte path, one byte per strobe
    task automatic bus_read(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        cs_n_out <= 1'b0;
        rd_n_out <= 1'b0;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        d = data_in;
        @(posedge clk_in);
        cs_n_out <= 1'b1;
        rd_n_out <= 1'b1;
        @(posedge clk_in);
    endtask
endmodule // rsr_host_model

// *** dv/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // Stimulus and observed signals
    logic       clk, rst_n, mr, alarm, ready, start, valid, mon_clk;
    logic [5:0] status;
    logic [7:0] rnd_byte, mon_byte, d;
    logic [3:0] nib, pat;
    wire  logic cs_n, rd_n, wr_n, oe, busy, pass, fail;
    wire  logic [2:0] addr;
    wire  logic [7:0] wdata, rdata;
    wire  logic [3:0] pcount;
    logic [7:0] exp_reg [2:7];
    int         failures, compares;

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    rsr_host_model i_host (.clk_in(clk), .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
        .addr_out(addr), .data_out(wdata), .data_in(rdata));

    rsr_status_regs i_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1), .CS_N_IN(cs_n),
        .RD_N_IN(rd_n), .WR_N_IN(wr_n), .ADDR_IN(addr), .DATA_IN(wdata), .DATA_OUT(rdata),
        .DATA_OE_OUT(oe), .MASTER_RESET_PIN_IN(mr), .ALARM_SELFTEST_COMMAND_IN(alarm),
        .RANDOM_READY_FLAG_IN(ready), .STATUS_BITS_IN(status), .RANDOM_BYTE_IN(rnd_byte),
        .TEST_START_IN(start), .SAMPLE_VALID_IN(valid), .SAMPLE_NIBBLE_IN(nib),
        .TEST_BUSY_OUT(busy), .TEST_PASS_OUT(pass), .TEST_FAIL_OUT(fail),
        .PATTERN_COUNT_OUT(pcount), .MONITOR_SAMPLE_CLOCK_IN(mon_clk), .MONITOR_BYTE_IN(mon_byte));

    // Byte compare with four-state equality
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Drive enable must follow a selected read and nothing else
    always @(negedge clk) begin
        if (rst_n === 1'b1) check8({7'h00, oe}, {7'h00, !cs_n && !rd_n}, "drive enable");
    end

    // Expected event count: fixed table in alarm mode, else matches saturated at FF
    function automatic logic [7:0] exp_count(input int hits, input logic alarm_on, input logic [3:0] p);
        if (alarm_on) return rsr_pkg::ALARM_EVENTS[8*p +: 8];
        return (hits > 255) ? 8'hFF : 8'(hits);
    endfunction

    task automatic give_verdict();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Status registers 2..7 against the expected copy
    task automatic check_regs();
        for (int a = 2; a < 8; a++) begin
            i_host.bus_read(3'(a), d);
            check8(d, exp_reg[a], "register");
        end
    endtask

    // One run-up test; expected count and verdict worked out here
    task automatic run_test(input bit all_match);
        int hits;
        int n;
        logic [3:0] v;
        logic [7:0] ev;
        logic ok;
        hits = 0;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (n = 0; n < 1000; n++) begin
            v = all_match ? pat : 4'($urandom_range(0, 15));
            if (v == pat) hits++;
            nib <= v;
            valid <= 1'b1;
            @(posedge clk);
        end
        valid <= 1'b0;
        ev = exp_count(hits, alarm, pat);
        ok = (ev >= exp_reg[4]) && (ev <= exp_reg[5]);
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n == 1) check8({7'h00, busy}, 8'h01, "busy while completing");
        end while (pass !== 1'b1 && fail !== 1'b1 && n < 40);
        if (pass !== 1'b1 && fail !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: no test result", $time);
            give_verdict();
        end
        check8({6'h00, pass, fail}, {6'h00, ok, !ok}, "verdict");
        check8({7'h00, busy}, 8'h00, "busy after result");
        exp_reg[2] = ev;
        exp_reg[3] = {4'h0, pat};
        if (ok) pat++;
        repeat (2) @(negedge clk);
        check8({4'h0, pcount}, {4'h0, pat}, "pattern counter");
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        mr = 1'b0;
        alarm = 1'b0;
        ready = 1'b0;
        start = 1'b0;
        valid = 1'b0;
        mon_clk = 1'b0;
        nib = 4'h0;
        pat = 4'h0;
        failures = 0;
        compares = 0;
        void'($urandom(32'hDE9A));
        status = 6'($urandom);
        rnd_byte = 8'($urandom);
        mon_byte = 8'($urandom);
        foreach (exp_reg[i]) exp_reg[i] = 8'h00;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        check_regs();
        i_host.bus_read(rsr_pkg::ADDR_STATUS, d);
        check8(d, {2'b00, status}, "status");
        i_host.bus_read(rsr_pkg::ADDR_RANDOM, d);
        check8(d, rnd_byte, "random byte");
        // Host loads both limits before trusting the test
        for (int k = 0; k < 4; k++) begin
            exp_reg[4] = (k == 3) ? 8'h00 : 8'($urandom);
            exp_reg[5] = (k == 3) ? 8'hFF : 8'($urandom);
            i_host.bus_write(rsr_pkg::ADDR_FLOOR, exp_reg[4]);
            i_host.bus_write(rsr_pkg::ADDR_CEILING, exp_reg[5]);
            check_regs();
        end
        run_test(1'b0);
        check_regs();
        // All samples match: saturated count above the ceiling fails
        exp_reg[5] = 8'hFE;
        i_host.bus_write(rsr_pkg::ADDR_CEILING, exp_reg[5]);
        run_test(1'b1);
        check_regs();
        // Master reset clears count only
        @(posedge clk);
        mr <= 1'b1;
        @(posedge clk);
        mr <= 1'b0;
        exp_reg[2] = 8'h00;
        check_regs();
        // Monitor tap used for testing only, never as random output
        @(posedge clk);
        mon_clk <= 1'b1;
        @(posedge clk);
        exp_reg[7] = mon_byte;
        mon_clk <= 1'b0;
        mon_byte <= ~mon_byte;
        check_regs();
        // Alarm mode: fixed count, then fixed byte sequence
        @(posedge clk);
        alarm <= 1'b1;
        exp_reg[5] = 8'hFF;
        i_host.bus_write(rsr_pkg::ADDR_CEILING, exp_reg[5]);
        run_test(1'b0);
        @(posedge clk);
        ready <= 1'b1;
        exp_reg[6] = 8'h43;
        check_regs();
        for (int k = 0; k < 67; k++) begin
            i_host.bus_read(rsr_pkg::ADDR_RANDOM, d);
            check8(d, rsr_pkg::ALARM_BYTES[k], "alarm byte");
        end
        i_host.bus_read(rsr_pkg::ADDR_RANDOM, d);
        exp_reg[6] = 8'h00;
        // Writes to read-only places are dropped
        for (int a = 2; a < 8; a++) begin
            if (a != 4 && a != 5) i_host.bus_write(3'(a), 8'($urandom));
        end
        check_regs();
        @(posedge clk);
        ready <= 1'b0;
        @(posedge clk);
        ready <= 1'b1;
        i_host.bus_read(rsr_pkg::ADDR_REMAIN, d);
        check8(d, 8'h43, "byte counter preset");
        give_verdict();
    end
endmodule // tb
